/* File: vfd_host_pkg.sv */
// Constants shared by the display host interface.
// Assumes a single 25 MHz clock domain; pins are synchronised inside.
package vfd_host_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_HZ = 25000000;
  localparam int POR_TIME_MS = 100;
  localparam int POR_CYCLES = (CLK_HZ / 1000) * POR_TIME_MS;

  // ==========================================================
  // Interface modes, fixed by jumpers
  // ==========================================================
  localparam logic [1:0] MODE_ESTROBE = 2'h0;
  localparam logic [1:0] MODE_RDWR = 2'h1;
  localparam logic [1:0] MODE_SERIAL = 2'h2;

  // ==========================================================
  // Address counter limits
  // ==========================================================
  localparam logic [6:0] DRAM_LINE0_END = 7'h27;
  localparam logic [6:0] DRAM_LINE1_BEG = 7'h40;
  localparam logic [6:0] DRAM_LINE1_END = 7'h67;
  localparam logic [6:0] GRAM_END = 7'h3f;
  localparam logic [6:0] AC_RESET = 7'h00;

  // ==========================================================
  // Serial framing
  // ==========================================================
  localparam logic [4:0] START_PREFIX = 5'h1f;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ==========================================================
  // AXI4-Lite register map
  // ==========================================================
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_LAST = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : vfd_host_pkg

/* File: vfd_host_interface.sv */
// Host-side link of a character display controller: parallel and serial
// receivers, address counter and an AXI4-Lite window onto them.
// Assumes host pins are asynchronous to aclk; instruction execution
// beyond the address counter lives elsewhere.
//
// Summary of operation
// - Parallel value moves as byte or two nibbles
// - Nibbles high first on upper four lines
// - Register select low instruction, high data
// - Strobe mode writes capture on strobe fall
// - Strobe mode reads drive after strobe rise
// - Separate strobes: write captured on rise
// - Separate strobes: read driven after fall
// - Serial cycle is two bytes, MSB first
// - Start byte: five ones, rw, rs, zero
// - Start rw bit set means read
// - Start rs bit set means data
// - Serial write bits sampled on clock rise
// - Serial read shifts out after clock falls
// - Frame strobe high to low; must end high
// - Internal power-up reset, 100 ms
// - External reset in parallel modes only
// - Mode and reset option are jumper inputs
// - Display increment wraps 27 to 40, 67 to 00
// - Display decrement wraps 40 to 27, 00 to 67
// - Glyph step wraps between 3F and 00
// - Display address doubles as cursor position
// - Busy indication always reads zero
// - Display addresses limited to two ranges; display loads take ac_load_val unchecked
// - Status read: busy bit 7, counter below
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module vfd_host_interface
  import vfd_host_pkg::*;
#(
  parameter int POR_COUNT = POR_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Jumper configuration
  input wire logic [1:0] mode_sel,
  input wire logic nibble_mode,
  input wire logic ext_reset_en,
  input wire logic ext_reset_n,
  // Parallel bus
  input wire logic register_select,
  input wire logic rw_select,
  input wire logic enable_strobe,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe_n,
  // Serial link
  input wire logic frame_strobe,
  input wire logic serial_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_oe_n,
  // Received values to the instruction engine
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  output logic cmd_is_data,
  output logic [6:0] cursor_pos,
  output logic ready,
  // Instruction engine inputs
  input wire logic [7:0] ram_rdata,
  input wire logic ac_load,
  input wire logic [6:0] ac_load_val,
  input wire logic glyph_sel,
  input wire logic dir_set,
  input wire logic dir_inc,
  input wire logic clear_disp,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ========================================================
  // Address counter stepping
  // ========================================================
  function automatic logic [6:0] ac_step(input logic [6:0] a,
                                         input logic inc,
                                         input logic glyph);
    logic [6:0] r;
    r = inc ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (glyph) begin
      r = r & GRAM_END;
    end else if (inc) begin
      if (a == DRAM_LINE0_END) r = DRAM_LINE1_BEG;
      else if (a == DRAM_LINE1_END) r = AC_RESET;
    end else begin
      if (a == DRAM_LINE1_BEG) r = DRAM_LINE0_END;
      else if (a == AC_RESET) r = DRAM_LINE1_END;
    end
    return r;
  endfunction : ac_step

  // ========================================================
  // Synchronisers
  // ========================================================
  // Bits: 0 en, 1 wr_n, 2 rd_n, 3 stb, 4 sck, 5 ext_rst_n
  logic [5:0] s1_r, s2_r, s3_r;
  logic [10:0] dq1_r, dq2_r;
  wire [5:0] pins = {ext_reset_n, serial_clk, frame_strobe,
                     read_strobe_n, write_strobe_n, enable_strobe};
  always_ff @(posedge aclk) begin
    s1_r <= pins;
    s2_r <= s1_r;
    s3_r <= s2_r;
    dq1_r <= {serial_in, rw_select, register_select, db_in};
    dq2_r <= dq1_r;
  end
  wire [5:0] rise = s2_r & ~s3_r;
  wire [5:0] fall = ~s2_r & s3_r;
  wire [7:0] db_s = dq2_r[7:0];
  wire rs_s = dq2_r[8];
  wire rw_s = dq2_r[9];
  wire si_s = dq2_r[10];
  wire serial_mode = (mode_sel == MODE_SERIAL);

  // ========================================================
  // Reset: bus reset, power-up counter, external pin
  // ========================================================
  logic [31:0] por_cnt_r;
  wire por_done = (por_cnt_r >= 32'(POR_COUNT));
  wire ext_rst = ext_reset_en && !serial_mode && !s2_r[5];
  wire srst = !aresetn || ext_rst;
  always_ff @(posedge aclk) begin
    if (srst) por_cnt_r <= '0;
    else if (!por_done) por_cnt_r <= por_cnt_r + 32'h1;
  end
  assign ready = por_done;
  wire live = por_done && !srst;

  // ========================================================
  // Parallel receiver
  // ========================================================
  wire par_wr = (mode_sel == MODE_ESTROBE) ? (fall[0] && !rw_s)
              : (mode_sel == MODE_RDWR) ? rise[1] : 1'b0;
  wire par_rd = (mode_sel == MODE_ESTROBE) ? (rise[0] && rw_s)
              : (mode_sel == MODE_RDWR) ? fall[2] : 1'b0;
  wire par_rd_end = (mode_sel == MODE_ESTROBE) ? fall[0] : rise[2];
  logic hi_half_r, rd_half_r;
  logic [3:0] hi_nib_r;
  wire par_done = par_wr && (!nibble_mode || hi_half_r);
  wire [7:0] par_val = nibble_mode ? {hi_nib_r, db_s[7:4]} : db_s;

  // ========================================================
  // Serial receiver
  // ========================================================
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r, start_r, tx_r;
  logic second_r, in_frame_r;
  wire sck_rise = rise[4] && in_frame_r;
  wire sck_fall = fall[4] && in_frame_r;
  wire byte_end = sck_rise && (bit_cnt_r == BITS_PER_BYTE - 4'h1);
  wire [7:0] sh_nxt = {sh_r[6:0], si_s};
  wire start_ok = (sh_nxt[7:3] == START_PREFIX) && !sh_nxt[0];
  wire ser_read = start_r[2];
  wire ser_rs = start_r[1];
  wire ser_wr_end = rise[3] && in_frame_r && second_r && !ser_read
                    && bit_cnt_r == BITS_PER_BYTE;

  // ========================================================
  // Read data and address counter
  // ========================================================
  logic [6:0] ac_r;
  logic inc_r, glyph_r;
  wire [7:0] status_byte = {1'b0, ac_r};
  wire rd_inc = par_rd && (nibble_mode ? rd_half_r : 1'b1);
  wire rd_data_sel = serial_mode ? ser_rs : rs_s;
  wire [7:0] rd_val = rd_data_sel ? ram_rdata : status_byte;
  logic [7:0] par_q_r;
  logic cmd_valid_r;

  always_ff @(posedge aclk) begin
    if (!live) begin
      hi_half_r <= 1'b0;
      rd_half_r <= 1'b0;
      hi_nib_r <= '0;
      db_oe_n <= 1'b1;
      par_q_r <= '0;
    end else begin
      if (par_wr && nibble_mode) hi_half_r <= !hi_half_r;
      if (par_wr && !hi_half_r) hi_nib_r <= db_s[7:4];
      if (par_rd) begin
        db_oe_n <= 1'b0;
        if (nibble_mode) rd_half_r <= !rd_half_r;
        par_q_r <= (nibble_mode && rd_half_r) ? {rd_val[3:0], 4'h0}
                                               : rd_val;
      end else if (par_rd_end) begin
        db_oe_n <= 1'b1;
      end
    end
  end
  assign db_out = par_q_r;

  always_ff @(posedge aclk) begin
    if (!live || !serial_mode || rise[3]) begin
      in_frame_r <= 1'b0;
      bit_cnt_r <= '0;
      second_r <= 1'b0;
      serial_oe_n <= 1'b1;
    end else begin
      if (fall[3]) in_frame_r <= 1'b1;
      if (sck_rise && !(second_r && ser_read)) begin
        sh_r <= sh_nxt;
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (byte_end && !second_r) begin
          // Bad start byte aborts until the strobe rises again
          in_frame_r <= start_ok;
          start_r <= sh_nxt;
          second_r <= 1'b1;
          bit_cnt_r <= '0;
          tx_r <= sh_nxt[1] ? ram_rdata : status_byte;
        end
      end
      if (sck_fall && second_r && ser_read) begin
        serial_oe_n <= 1'b0;
        serial_out <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // The host's 1 us clock gap is not checked: decoding is per edge
  wire ser_rd_end = rise[3] && in_frame_r && second_r && ser_read;

  always_ff @(posedge aclk) begin
    if (!live) begin
      cmd_valid_r <= 1'b0;
      cmd_data <= '0;
      cmd_is_data <= 1'b0;
    end else begin
      cmd_valid_r <= par_done || ser_wr_end;
      if (par_done) begin
        cmd_data <= par_val;
        cmd_is_data <= rs_s;
      end else if (ser_wr_end) begin
        cmd_data <= sh_r;
        cmd_is_data <= ser_rs;
      end
    end
  end
  assign cmd_valid = cmd_valid_r;

  wire data_wr = (par_done && rs_s) || (ser_wr_end && ser_rs);
  wire data_rd = (rd_inc && rs_s && !serial_mode) || (ser_rd_end && ser_rs);
  always_ff @(posedge aclk) begin
    if (!live || clear_disp) begin
      ac_r <= AC_RESET;
      inc_r <= 1'b1;
      glyph_r <= 1'b0;
    end else begin
      if (dir_set) inc_r <= dir_inc;
      if (ac_load) begin
        ac_r <= glyph_sel ? (ac_load_val & GRAM_END) : ac_load_val;
        glyph_r <= glyph_sel;
      end else if (data_wr || data_rd) begin
        ac_r <= ac_step(ac_r, inc_r, glyph_r);
      end
    end
  end
  assign cursor_pos = ac_r;

  // ========================================================
  // AXI4-Lite slave (read-only window, writes answer SLVERR)
  // ========================================================
  logic aw_got_r, w_got_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_got_r <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_got_r <= 1'b1;
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_SLVERR;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;

  wire [31:0] reg_status = {20'h0, ready, serial_mode, inc_r, glyph_r,
                            1'b0, ac_r};
  wire [31:0] reg_last = {23'h0, cmd_is_data, cmd_data};
  wire ar_ok = (s_axi_araddr == REG_STATUS) || (s_axi_araddr == REG_LAST)
               || (s_axi_araddr == REG_RDATA);
  wire [31:0] ar_val = (s_axi_araddr == REG_STATUS) ? reg_status
                     : (s_axi_araddr == REG_LAST) ? reg_last
                     : {24'h0, ram_rdata};
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= ar_ok ? ar_val : 32'h0;
      s_axi_rresp <= ar_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ========================================================
  // Assertions
  // ========================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!live);
  wire ac_free = !ac_load && !clear_disp;
  wire cur_in_dram = (cursor_pos <= DRAM_LINE0_END) || (cursor_pos
                     >= DRAM_LINE1_BEG && cursor_pos <= DRAM_LINE1_END);
  a_inc_wrap: assert property (ac_free && data_wr && inc_r
    && !glyph_r && ac_r == DRAM_LINE0_END |=> ac_r == DRAM_LINE1_BEG)
    else $error("display increment wrap wrong");
  a_dec_wrap: assert property (ac_free && data_wr && !inc_r
    && !glyph_r && ac_r == AC_RESET |=> ac_r == DRAM_LINE1_END)
    else $error("display decrement wrap wrong");
  a_glyph_range: assert property (glyph_r |-> ac_r <= GRAM_END)
    else $error("glyph address out of range");
  a_busy_zero: assert property (par_rd && !rs_s
    && !(nibble_mode && rd_half_r) |=> !db_out[7])
    else $error("busy indication not zero");
  a_estb_write: assert property (fall[0] && !rw_s
    && mode_sel == MODE_ESTROBE && !nibble_mode
    |=> cmd_valid && cmd_data == $past(db_s))
    else $error("strobe write not captured");
  a_rdwr_read: assert property (mode_sel == MODE_RDWR && fall[2]
    |=> !db_oe_n)
    else $error("read strobe did not drive bus");
  a_cursor_pos: assert property (ac_free && !glyph_r
    && (data_wr || data_rd) && cur_in_dram |=> cur_in_dram)
    else $error("display step left valid range");
  a_clear_inc: assert property (clear_disp
    |=> inc_r && ac_r == AC_RESET)
    else $error("clear did not set increment");

endmodule : vfd_host_interface

/* File: host_model.sv */
// Host processor model driving the parallel and serial pins of the link.
// Assumes aclk from the bench; every pin change follows its rising edge.
`timescale 1ns/100ps
module host_model
  import vfd_host_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Device outputs
  input wire logic [7:0] db_out,
  input wire logic db_oe_n,
  input wire logic serial_out,
  input wire logic serial_oe_n,
  // Host pins
  output logic register_select,
  output logic rw_select,
  output logic enable_strobe,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic [7:0] db_in,
  output logic frame_strobe,
  output logic serial_clk,
  output logic serial_in
);
  initial begin
    {register_select, rw_select, enable_strobe} = 3'h0;
    {write_strobe_n, read_strobe_n, frame_strobe, serial_clk} = 4'hf;
    db_in = 8'hff;
    serial_in = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // ==========================================================
  // Parallel strobe; released lines sit at the pull-up level
  // ==========================================================
  task automatic beat(input logic [1:0] m, input logic rw,
                      input logic [7:0] v, output logic [7:0] q);
    cyc(1);
    rw_select <= rw;
    db_in <= rw ? 8'hff : v;
    cyc(2);
    enable_strobe <= (m == MODE_ESTROBE);
    write_strobe_n <= (m == MODE_ESTROBE) || rw;
    read_strobe_n <= (m == MODE_ESTROBE) || !rw;
    cyc(8);
    @(negedge aclk);
    q = db_oe_n ? 8'hff : db_out;
    @(posedge aclk);
    enable_strobe <= 1'b0;
    write_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    cyc(6);
    db_in <= 8'hff;
    cyc(4);
  endtask : beat

  // ==========================================================
  // Serial bit: clock idles high, data changes while low
  // ==========================================================
  task automatic sbit(input logic b, output logic q);
    serial_clk <= 1'b0;
    serial_in <= b;
    cyc(4);
    serial_clk <= 1'b1;
    cyc(3);
    // Late sample leaves the device's synchroniser delay some margin
    @(negedge aclk);
    q = serial_oe_n ? 1'b1 : serial_out;
    @(posedge aclk);
  endtask : sbit

  task automatic frame(input logic [7:0] sb, input logic [7:0] v,
                       input int nb, output logic [7:0] q);
    logic d;
    cyc(1);
    frame_strobe <= 1'b0;
    cyc(4);
    for (int i = 7; i >= 0; i--) sbit(sb[i], d);
    cyc(30);
    for (int i = 7; i > 7 - nb; i--) begin
      sbit(sb[2] ? i[0] : v[i], d);
      q[i] = d;
    end
    cyc(4);
    frame_strobe <= 1'b1;
    cyc(12);
  endtask : frame

  task automatic xfer(input logic [1:0] m, input logic nib, rw, sel,
                      input logic [7:0] v, output logic [7:0] q);
    logic [7:0] a, b;
    register_select <= sel;
    if (m == MODE_SERIAL) begin
      frame({5'h1f, rw, sel, 1'b0}, v, 8, q);
    end else if (nib) begin
      beat(m, rw, {v[7:4], ~v[3:0]}, a);
      beat(m, rw, {v[3:0], v[7:4]}, b);
      q = {a[7:4], b[7:4]};
    end else begin
      beat(m, rw, v, q);
    end
  endtask : xfer
endmodule : host_model

/* File: tb.sv */
// Self-checking bench: host model on the pins, AXI4-Lite reads on the side.
// Assumes POR_COUNT shortened to 20 cycles.
`timescale 1ns/100ps
module tb;
  import vfd_host_pkg::*;
  localparam int POR_SIM = 20;
  logic aclk, aresetn, nibble_mode, ext_reset_en, ext_reset_n;
  logic [1:0] mode_sel, md, r;
  logic register_select, rw_select, enable_strobe, write_strobe_n;
  logic read_strobe_n, frame_strobe, serial_clk, serial_in, serial_out;
  logic db_oe_n, serial_oe_n, cmd_valid, cmd_is_data, ready;
  logic [7:0] db_in, db_out, cmd_data, ram_rdata, rd, v;
  logic [6:0] cursor_pos, ac_load_val, exp_cnt;
  logic ac_load, glyph_sel, dir_set, dir_inc, clear_disp;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [8:0] rxq[$];
  logic [8:0] last_rx;
  int miscompares, total_checks, seed, k;
  logic [6:0] cv[7] = '{7'h27, 7'h67, 7'h40, 7'h00, 7'h3f, 7'h00, 7'h05};
  logic cg[7] = '{0, 0, 0, 0, 1, 1, 0};
  logic ci[7] = '{1, 1, 0, 0, 1, 0, 1};

  vfd_host_interface #(.POR_COUNT(POR_SIM)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .mode_sel(mode_sel),
    .nibble_mode(nibble_mode), .ext_reset_en(ext_reset_en),
    .ext_reset_n(ext_reset_n), .register_select(register_select),
    .rw_select(rw_select), .enable_strobe(enable_strobe),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .db_in(db_in), .db_out(db_out), .db_oe_n(db_oe_n),
    .frame_strobe(frame_strobe), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_oe_n(serial_oe_n), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_is_data(cmd_is_data),
    .cursor_pos(cursor_pos), .ready(ready), .ram_rdata(ram_rdata),
    .ac_load(ac_load), .ac_load_val(ac_load_val),
    .glyph_sel(glyph_sel), .dir_set(dir_set), .dir_inc(dir_inc),
    .clear_disp(clear_disp), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  host_model u_host (
    .aclk(aclk), .db_out(db_out), .db_oe_n(db_oe_n),
    .serial_out(serial_out), .serial_oe_n(serial_oe_n),
    .register_select(register_select), .rw_select(rw_select),
    .enable_strobe(enable_strobe), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .db_in(db_in),
    .frame_strobe(frame_strobe), .serial_clk(serial_clk),
    .serial_in(serial_in));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk)
    if (cmd_valid === 1'b1) rxq.push_back({cmd_is_data, cmd_data});

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Bounded wait, sampled at the falling edge before the taking edge
  task automatic hs(ref logic s, output int n);
    for (n = 0; n < 2000; n++) begin
      @(negedge aclk);
      if (s === 1'b1) break;
    end
    if (n == 2000) begin
      miscompares++;
      end_of_test();
    end
  endtask : hs

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] q,
                        output logic [1:0] rr);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hs(s_axi_arready, n);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    hs(s_axi_rvalid, n);
    q = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic axi_wr(input logic [3:0] a, output logic [1:0] rr);
    int n;
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= $random(seed);
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    {aw, w} = 2'h3;
    for (n = 0; n < 50 && (aw || w); n++) begin
      @(negedge aclk);
      aw = aw && (s_axi_awready !== 1'b1);
      w = w && (s_axi_wready !== 1'b1);
      @(posedge aclk);
      if (!aw) s_axi_awvalid <= 1'b0;
      if (!w) s_axi_wvalid <= 1'b0;
    end
    if (aw || w) begin
      miscompares++;
      end_of_test();
    end
    hs(s_axi_bvalid, n);
    rr = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  function automatic logic [6:0] nxt(input logic [6:0] a, input logic g, i);
    if (g && i) return (a == 7'h3f) ? 7'h00 : a + 7'h01;
    if (g) return (a == 7'h00) ? 7'h3f : a - 7'h01;
    if (i) return (a == 7'h27) ? 7'h40 : (a == 7'h67) ? 7'h00 : a + 7'h01;
    return (a == 7'h40) ? 7'h27 : (a == 7'h00) ? 7'h67 : a - 7'h01;
  endfunction : nxt

  task automatic load_cnt(input logic [6:0] a, input logic g, i);
    @(posedge aclk);
    {ac_load, dir_set, glyph_sel, dir_inc} <= {2'h3, g, i};
    ac_load_val <= a;
    @(posedge aclk);
    {ac_load, dir_set, glyph_sel} <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask : load_cnt

  task automatic do_reset(input logic [1:0] m, input logic nib);
    int n;
    @(posedge aclk);
    {aresetn, mode_sel, nibble_mode} <= {1'b0, m, nib};
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    chk(db_oe_n, 1'b1, "db_oe_n in reset");
    @(posedge aclk);
    aresetn <= 1'b1;
    hs(ready, n);
    chk(n >= POR_SIM - 1, 1, "power-up delay");
    @(posedge aclk);
    clear_disp <= 1'b1;
    @(posedge aclk);
    clear_disp <= 1'b0;
    exp_cnt = 7'h00;
  endtask : do_reset

  task automatic pulse_ext;
    @(posedge aclk);
    ext_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    ext_reset_n <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask : pulse_ext

  initial begin
    repeat (100000) @(posedge aclk);
    miscompares++;
    end_of_test();
  end

  initial begin
    seed = 52622;
    {aresetn, ext_reset_en, ext_reset_n, nibble_mode, mode_sel} = 6'h08;
    {ac_load, glyph_sel, dir_set, dir_inc, clear_disp} = 5'h00;
    {ac_load_val, ram_rdata} = 15'h0000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    for (int m = 0; m < 4; m++) begin
      md = (m == 3) ? MODE_SERIAL : (m == 2) ? MODE_RDWR : MODE_ESTROBE;
      do_reset(md, m == 1);
      for (int i = 0; i < 8; i++) begin
        if (i < 7) load_cnt(cv[i], cg[i], ci[i]);
        if (i < 7) exp_cnt = cv[i];
        v = $random(seed);
        u_host.xfer(md, m == 1, 1'b0, i < 7, v, rd);
        last_rx = {i < 7, v};
        if (i < 7) exp_cnt = nxt(exp_cnt, cg[i], ci[i]);
        chk(rxq.size(), 1, "received count");
        if (rxq.size() > 0)
          chk(rxq.pop_front(), last_rx, "received");
        chk(cursor_pos, exp_cnt, "cursor");
      end
      u_host.xfer(md, m == 1, 1'b1, 1'b0, 8'h00, rd);
      chk(rd, {1'b0, exp_cnt}, "status byte");
      @(posedge aclk);
      ram_rdata <= $random(seed);
      u_host.xfer(md, m == 1, 1'b1, 1'b1, 8'h00, rd);
      chk(rd, ram_rdata, "read data");
      exp_cnt = nxt(exp_cnt, 1'b0, 1'b1);
      chk(cursor_pos, exp_cnt, "cursor after read");
      axi_rd(REG_STATUS, d, r);
      chk(d[11:0], {1'b1, m == 3, 3'h4, exp_cnt},
          "status word");
      $display("mode %0d done", m);
    end
    // Bad last start bit, bad prefix, then a frame cut short
    u_host.frame(8'hfb, 8'h55, 8, rd);
    u_host.frame(8'h7a, 8'h55, 8, rd);
    u_host.frame(8'hfa, 8'h55, 4, rd);
    chk(rxq.size(), 0, "dropped frames");
    axi_rd(REG_LAST, d, r);
    chk(d[8:0], last_rx, "last received");
    axi_rd(REG_RDATA, d, r);
    chk(d[7:0], ram_rdata, "ram data word");
    axi_rd(4'hc, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk(r, RESP_SLVERR, "unmapped read response");
    axi_wr(REG_STATUS, r);
    chk(r, RESP_SLVERR, "write response");
    ext_reset_en <= 1'b1;
    pulse_ext();
    chk(cursor_pos, exp_cnt, "serial ignores ext reset");
    $display("serial extras done");
    do_reset(MODE_ESTROBE, 1'b0);
    load_cnt(7'h12, 1'b0, 1'b1);
    pulse_ext();
    chk(cursor_pos, 7'h00, "ext reset");
    hs(ready, k);
    $display("ext reset done");
    end_of_test();
  end
endmodule : tb
